// ---- tdc_pkg.sv ----
// Package of constants, types and the state record for the trap and debug-entry controller.
package tdc_pkg;
   // Register offsets on the plain register port (byte addresses).
   localparam logic [7:0] OFF_MSTATUS = 8'h00;
   localparam logic [7:0] OFF_MIE = 8'h04;
   localparam logic [7:0] OFF_MIP = 8'h08;
   localparam logic [7:0] OFF_MTVEC = 8'h0C;
   localparam logic [7:0] OFF_MEPC = 8'h10;
   localparam logic [7:0] OFF_MCAUSE = 8'h14;
   localparam logic [7:0] OFF_DCSR = 8'h18;
   localparam logic [7:0] OFF_DPC = 8'h1C;
   localparam logic [7:0] OFF_DSCRATCH0 = 8'h20;
   localparam logic [7:0] OFF_DSCRATCH1 = 8'h24;
   localparam logic [7:0] OFF_TSELECT = 8'h28;
   localparam logic [7:0] OFF_TDATA1 = 8'h2C;
   localparam logic [7:0] OFF_TDATA2 = 8'h30;
   // Field positions.
   localparam int MSTATUS_MIE_BIT = 3;
   localparam int MSTATUS_MPIE_BIT = 7;
   localparam int DCSR_EBREAKM_BIT = 15;
   localparam int DCSR_CAUSE_LSB = 6;
   localparam int TDATA1_EXEC_BIT = 2;
   localparam int TRIGGER_DEBUG_ONLY_BIT_BIT = 27;
   localparam int TDATA1_TYPE_LSB = 28;
   localparam logic [3:0] TDATA1_TYPE_MATCH = 4'h2;
   localparam int MTVEC_BASE_LSB = 8;
   // Interrupt lines and the mask of lines that exist.
   localparam logic [4:0] IRQ_MSI = 5'h03;
   localparam logic [4:0] IRQ_MTI = 5'h07;
   localparam logic [4:0] IRQ_MEI = 5'h0B;
   localparam int IRQ_CUSTOM_LSB = 16;
   localparam logic [31:0] IRQ_MASK = 32'hFFFF_0888;
   // Exception cause codes.
   localparam logic [4:0] CAUSE_ILLEGAL = 5'h02;
   localparam logic [4:0] CAUSE_BREAK = 5'h03;
   localparam logic [4:0] CAUSE_ECALL_M = 5'h0B;
   // Debug entry causes.
   localparam logic [2:0] DBG_CAUSE_EBREAK = 3'h1;
   localparam logic [2:0] DBG_CAUSE_TRIGGER = 3'h2;
   localparam logic [2:0] DBG_CAUSE_HALTREQ = 3'h3;
   // Fixed instruction encodings.
   localparam logic [31:0] INSN_ECALL = 32'h0000_0073;
   localparam logic [31:0] INSN_EBREAK = 32'h0010_0073;
   localparam logic [31:0] INSN_CEBREAK = 32'h0000_9002;
   localparam logic [31:0] INSN_URET = 32'h0020_0073;
   localparam logic [31:0] INSN_MRET = 32'h3020_0073;
   localparam logic [31:0] INSN_DRET = 32'h7B20_0073;
   localparam logic [6:0] OPC_SYSTEM = 7'h73;
   localparam logic [11:0] CSR_DEBUG_LO = 12'h7B0;
   localparam logic [11:0] CSR_DEBUG_HI = 12'h7B3;
   localparam logic [11:0] CSR_FLOAT_HI = 12'h003;
   // Build options: no floating point and no custom instructions.
   localparam bit FPU_PARAM = 1'b0;
   localparam bit CUSTOM_EXT_PARAM = 1'b0;

   typedef enum logic [1:0] {ST_HAVERESET, ST_RUNNING, ST_HALTED} tdc_mode_t;

   // Decode-stage instruction presented by the pipeline.
   typedef struct packed {
      logic valid;
      logic [31:0] insn;
      logic [31:0] pc;
   } tdc_insn_t;

   // Redirect order sent back to the fetch unit.
   typedef struct packed {
      logic valid;
      logic kill;
      logic [31:0] pc;
   } tdc_redir_t;

   typedef struct packed {
      logic [31:0] irq_s1;
      logic [31:0] irq_s2;
      logic fe_s1;
      logic fe_s2;
      tdc_mode_t mode;
      logic mie_g;
      logic mpie;
      logic [31:0] mie_en;
      logic [23:0] mtvec_base;
      logic mtvec_mode;
      logic [31:0] mepc;
      logic mcause_irq;
      logic [4:0] mcause_code;
      logic ebreakm;
      logic [2:0] dcause;
      logic [31:0] dpc;
      logic [31:0] dscratch0;
      logic [31:0] dscratch1;
      logic trig_exec;
      logic [31:0] tdata2;
      logic irq_ack;
      logic [4:0] irq_id;
      tdc_redir_t redir;
      logic [31:0] rdata;
      logic havereset;
      logic running;
      logic halted;
   } tdc_state_t;
endpackage : tdc_pkg

// ---- tdc_trap_ctrl.sv ----
// Trap, interrupt and debug-entry controller for a 32-bit machine-mode core.
`timescale 1ns/1ps
// Summary of operation
// - After reset every interrupt enable is clear.
// - Take an interrupt only with global and line enable set; lines are levels.
// - Custom lines 31..16 sit in the upper half of enable and pending.
// - Priority is 31..16, then 11, then 3, timer 7 last.
// - Acknowledge pulses one cycle with the 5-bit index of the taken line.
// - In Debug Mode every interrupt is ignored.
// - Cause codes are 2 illegal, 3 breakpoint, 11 machine environment call.
// - Illegal instruction and environment call can never be suppressed.
// - Undefined major opcodes are illegal; without floating point all float work is illegal.
// - Trap entry clears the global enable; hardware never nests traps.
// - Debug entry saves PC in DPC, cause in DCSR, jumps to halt address.
// - Enter Debug Mode on halt request, trigger match, or ebreak with EBREAKM.
// - The decode instruction seen as the halt request rises does not execute.
// - Reset-seen, running and halted are never asserted together.
// - Reset-seen is set in reset, cleared after fetch permit is seen high.
// - Ebreak in Debug Mode returns to the halt address, no status change.
// - Exceptions, mret or uret in Debug Mode go to the debug exception address.
// - Debug CSR access outside Debug Mode is an illegal instruction.
// - One trigger matches instruction addresses and can enter Debug Mode.
// - Trigger debug-only bit reads 1; outside Debug Mode trigger writes are dropped.
// - Lines 11, 7 and 3 are machine external, timer and software interrupts.
// - Trap entry saves PC in mepc and stacks the enable; mret restores both.
// - Exceptions go to the base; vectored interrupts go to base plus four times id.
module tdc_trap_ctrl (
   input wire logic i_clk,
   input wire logic i_rst,
   input wire logic [31:0] i_irq,
   input wire logic i_fetch_enable,
   input wire logic i_debug_req,
   input wire logic [31:0] i_halt_entry_address,
   input wire logic [31:0] i_debug_exception_address,
   input wire tdc_pkg::tdc_insn_t i_insn,
   input wire logic [7:0] i_addr,
   input wire logic [31:0] i_wdata,
   input wire logic i_we,
   input wire logic i_re,
   output logic [31:0] o_rdata,
   output logic o_irq_ack,
   output logic [4:0] o_taken_interrupt_index,
   output tdc_pkg::tdc_redir_t o_redir,
   output logic o_havereset,
   output logic o_running,
   output logic o_halted
);
   import tdc_pkg::*;

   tdc_state_t st_r;
   tdc_state_t st_nxt;
   logic [31:0] irq_pend;
   logic irq_hit;
   logic [4:0] irq_sel;
   logic trig_hit;
   logic insn_illegal;
   logic is_ebreak;
   logic take_irq;
   logic [6:0] opc;
   logic [11:0] csr_num;

   // Enabled pending lines; the custom lines live in the upper half of both masks.
   assign irq_pend = st_r.irq_s2 & st_r.mie_en & IRQ_MASK;
   assign irq_hit = (|irq_pend) && st_r.mie_g && (st_r.mode == ST_RUNNING);
   assign opc = i_insn.insn[6:0];
   assign csr_num = i_insn.insn[31:20];
   assign is_ebreak = (i_insn.insn == INSN_EBREAK) || (i_insn.insn == INSN_CEBREAK);
   // Address trigger only fires in normal mode, so debug code cannot re-trip it.
   assign trig_hit = st_r.trig_exec && i_insn.valid && (i_insn.pc == st_r.tdata2) &&
                     (st_r.mode == ST_RUNNING);
   assign take_irq = irq_hit && i_insn.valid && !i_debug_req && !trig_hit;

   // Fixed priority; later assignments win, so the lowest priority is tested first.
   always_comb begin
      irq_sel = IRQ_MTI;
      if (irq_pend[IRQ_MSI]) begin
         irq_sel = IRQ_MSI;
      end
      if (irq_pend[IRQ_MEI]) begin
         irq_sel = IRQ_MEI;
      end
      for (int i = IRQ_CUSTOM_LSB; i < 32; i++) begin
         if (irq_pend[i]) begin
            irq_sel = 5'(i);
         end
      end
   end

   // Legality check on major opcodes; compressed forms are assumed checked upstream.
   always_comb begin
      insn_illegal = 1'b1;
      unique case (opc)
         7'h03, 7'h0F, 7'h13, 7'h17, 7'h23, 7'h33, 7'h37, 7'h63, 7'h67, 7'h6F: begin
            insn_illegal = 1'b0;
         end
         7'h07, 7'h27, 7'h43, 7'h47, 7'h4B, 7'h4F, 7'h53: begin
            insn_illegal = !FPU_PARAM;
         end
         7'h0B, 7'h2B, 7'h5B, 7'h7B: begin
            insn_illegal = !CUSTOM_EXT_PARAM;
         end
         OPC_SYSTEM: begin
            if (i_insn.insn[14:12] == 3'h0) begin
               insn_illegal = !((i_insn.insn == INSN_ECALL) || (i_insn.insn == INSN_EBREAK) ||
                                (i_insn.insn == INSN_MRET) || (i_insn.insn == INSN_URET) ||
                                ((i_insn.insn == INSN_DRET) && (st_r.mode == ST_HALTED)));
            end else if (i_insn.insn[14:12] == 3'h4) begin
               insn_illegal = 1'b1;
            end else if ((csr_num >= CSR_DEBUG_LO) && (csr_num <= CSR_DEBUG_HI)) begin
               insn_illegal = (st_r.mode != ST_HALTED);
            end else if ((csr_num != 12'h000) && (csr_num <= CSR_FLOAT_HI)) begin
               insn_illegal = !FPU_PARAM;
            end else begin
               insn_illegal = 1'b0;
            end
         end
         default: begin
            insn_illegal = !((opc[1:0] != 2'h3) || (i_insn.insn == INSN_CEBREAK));
         end
      endcase
   end

   // Next-state logic: synchronisers, bus, then trap sequencing; hardware wins over bus.
   always_comb begin
      st_nxt = st_r;
      st_nxt.irq_s1 = i_irq;
      st_nxt.irq_s2 = st_r.irq_s1;
      st_nxt.fe_s1 = i_fetch_enable;
      st_nxt.fe_s2 = st_r.fe_s1;
      st_nxt.irq_ack = 1'b0;
      st_nxt.redir = '0;
      st_nxt.rdata = 32'h0000_0000;
      // Read data for a strobe in this cycle appears in the next cycle only.
      if (i_re) begin
         unique case (i_addr)
            OFF_MSTATUS: begin
               st_nxt.rdata[MSTATUS_MIE_BIT] = st_r.mie_g;
               st_nxt.rdata[MSTATUS_MPIE_BIT] = st_r.mpie;
            end
            OFF_MIE: st_nxt.rdata = st_r.mie_en;
            OFF_MIP: st_nxt.rdata = st_r.irq_s2 & IRQ_MASK;
            OFF_MTVEC: st_nxt.rdata = {st_r.mtvec_base, 7'h00, st_r.mtvec_mode};
            OFF_MEPC: st_nxt.rdata = st_r.mepc;
            OFF_MCAUSE: st_nxt.rdata = {st_r.mcause_irq, 26'h0, st_r.mcause_code};
            OFF_DCSR: begin
               st_nxt.rdata[DCSR_EBREAKM_BIT] = st_r.ebreakm;
               st_nxt.rdata[DCSR_CAUSE_LSB +: 3] = st_r.dcause;
            end
            OFF_DPC: st_nxt.rdata = st_r.dpc;
            OFF_DSCRATCH0: st_nxt.rdata = st_r.dscratch0;
            OFF_DSCRATCH1: st_nxt.rdata = st_r.dscratch1;
            OFF_TDATA1: begin
               st_nxt.rdata[TDATA1_TYPE_LSB +: 4] = TDATA1_TYPE_MATCH;
               st_nxt.rdata[TRIGGER_DEBUG_ONLY_BIT_BIT] = 1'b1;
               st_nxt.rdata[TDATA1_EXEC_BIT] = st_r.trig_exec;
            end
            OFF_TDATA2: st_nxt.rdata = st_r.tdata2;
            default: st_nxt.rdata = 32'h0000_0000;
         endcase
      end
      if (i_we) begin
         unique case (i_addr)
            OFF_MSTATUS: begin
               st_nxt.mie_g = i_wdata[MSTATUS_MIE_BIT];
               st_nxt.mpie = i_wdata[MSTATUS_MPIE_BIT];
            end
            OFF_MIE: st_nxt.mie_en = i_wdata & IRQ_MASK;
            OFF_MTVEC: begin
               st_nxt.mtvec_base = i_wdata[31:MTVEC_BASE_LSB];
               st_nxt.mtvec_mode = i_wdata[0];
            end
            OFF_MEPC: st_nxt.mepc = {i_wdata[31:1], 1'b0};
            OFF_MCAUSE: begin
               st_nxt.mcause_irq = i_wdata[31];
               st_nxt.mcause_code = i_wdata[4:0];
            end
            OFF_DCSR: st_nxt.ebreakm = i_wdata[DCSR_EBREAKM_BIT];
            OFF_DPC: st_nxt.dpc = {i_wdata[31:1], 1'b0};
            OFF_DSCRATCH0: st_nxt.dscratch0 = i_wdata;
            OFF_DSCRATCH1: st_nxt.dscratch1 = i_wdata;
            OFF_TDATA1: begin
               if (st_r.mode == ST_HALTED) begin
                  st_nxt.trig_exec = i_wdata[TDATA1_EXEC_BIT];
               end
            end
            OFF_TDATA2: begin
               if (st_r.mode == ST_HALTED) begin
                  st_nxt.tdata2 = i_wdata;
               end
            end
            default: begin
            end
         endcase
      end
      // Trap and debug sequencing.
      unique case (st_r.mode)
         ST_HAVERESET: begin
            // Leave the reset-seen state only once the permit has been sampled high.
            if (st_r.fe_s2) begin
               st_nxt.mode = ST_RUNNING;
               if (i_debug_req) begin
                  st_nxt.mode = ST_HALTED;
                  st_nxt.dpc = i_insn.pc;
                  st_nxt.dcause = DBG_CAUSE_HALTREQ;
                  st_nxt.redir = '{valid: 1'b1, kill: 1'b1, pc: i_halt_entry_address};
               end
            end
         end
         ST_RUNNING: begin
            if (i_debug_req || trig_hit ||
                (i_insn.valid && is_ebreak && st_r.ebreakm && !irq_hit)) begin
               // Debug entry kills the decode instruction; halt request and trigger beat any interrupt, an enabled interrupt beats ebreak.
               st_nxt.mode = ST_HALTED;
               st_nxt.dpc = i_insn.pc;
               st_nxt.dcause = i_debug_req ? DBG_CAUSE_HALTREQ :
                               (trig_hit ? DBG_CAUSE_TRIGGER : DBG_CAUSE_EBREAK);
               st_nxt.redir = '{valid: 1'b1, kill: 1'b1, pc: i_halt_entry_address};
            end else if (take_irq) begin
               st_nxt.irq_ack = 1'b1;
               st_nxt.irq_id = irq_sel;
               st_nxt.mepc = i_insn.pc;
               st_nxt.mpie = st_r.mie_g;
               st_nxt.mie_g = 1'b0;
               st_nxt.mcause_irq = 1'b1;
               st_nxt.mcause_code = irq_sel;
               st_nxt.redir.valid = 1'b1;
               st_nxt.redir.kill = 1'b1;
               st_nxt.redir.pc = {st_r.mtvec_base, 8'h00};
               if (st_r.mtvec_mode) begin
                  st_nxt.redir.pc = {st_r.mtvec_base, 1'b0, irq_sel, 2'h0};
               end
            end else if (i_insn.valid) begin
               if (insn_illegal || is_ebreak || (i_insn.insn == INSN_ECALL)) begin
                  // No enable can mask illegal instruction or ecall; ebreak reaches here only with EBREAKM clear.
                  st_nxt.mcause_irq = 1'b0;
                  st_nxt.mcause_code = insn_illegal ? CAUSE_ILLEGAL :
                                       (is_ebreak ? CAUSE_BREAK : CAUSE_ECALL_M);
                  st_nxt.mepc = i_insn.pc;
                  st_nxt.mpie = st_r.mie_g;
                  st_nxt.mie_g = 1'b0;
                  st_nxt.redir = '{valid: 1'b1, kill: 1'b1, pc: {st_r.mtvec_base, 8'h00}};
               end else if (i_insn.insn == INSN_MRET) begin
                  st_nxt.mie_g = st_r.mpie;
                  st_nxt.mpie = 1'b1;
                  st_nxt.redir = '{valid: 1'b1, kill: 1'b1, pc: st_r.mepc};
               end
            end
         end
         ST_HALTED: begin
            // Debug code never touches machine status; it bounces between entries until dret returns to DPC.
            if (i_insn.valid) begin
               if (is_ebreak) begin
                  st_nxt.redir = '{valid: 1'b1, kill: 1'b1, pc: i_halt_entry_address};
               end else if (insn_illegal || (i_insn.insn == INSN_ECALL) ||
                            (i_insn.insn == INSN_MRET) || (i_insn.insn == INSN_URET)) begin
                  st_nxt.redir = '{valid: 1'b1, kill: 1'b1,
                                   pc: i_debug_exception_address};
               end else if (i_insn.insn == INSN_DRET) begin
                  st_nxt.mode = ST_RUNNING;
                  st_nxt.redir = '{valid: 1'b1, kill: 1'b1, pc: st_r.dpc};
               end
            end
         end
      endcase
      // Status pins decode the next mode so exactly one is ever high.
      st_nxt.havereset = (st_nxt.mode == ST_HAVERESET);
      st_nxt.running = (st_nxt.mode == ST_RUNNING);
      st_nxt.halted = (st_nxt.mode == ST_HALTED);
   end

   // State register; synchronous reset leaves every enable clear and reset-seen high.
   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         st_r <= '0;
         st_r.mode <= ST_HAVERESET;
         st_r.havereset <= 1'b1;
      end else begin
         st_r <= st_nxt;
      end
   end

   // Outputs come straight from the state register.
   assign o_rdata = st_r.rdata;
   assign o_irq_ack = st_r.irq_ack;
   assign o_taken_interrupt_index = st_r.irq_id;
   assign o_redir = st_r.redir;
   assign o_havereset = st_r.havereset;
   assign o_running = st_r.running;
   assign o_halted = st_r.halted;

   // Checks on the outputs against their causes.
   property p_status_onehot;
      @(posedge i_clk) disable iff (i_rst) $onehot({o_havereset, o_running, o_halted});
   endproperty
   a_status_onehot: assert property (p_status_onehot) else $error("status not one-hot");

   property p_reset_seen;
      @(posedge i_clk) i_rst |=> o_havereset && !o_irq_ack && (st_r.mie_en == 32'h0);
   endproperty
   a_reset_seen: assert property (p_reset_seen) else $error("reset state wrong");

   property p_ack_pulse;
      @(posedge i_clk) disable iff (i_rst) o_irq_ack |-> !st_r.mie_g ##1 !o_irq_ack;
   endproperty
   a_ack_pulse: assert property (p_ack_pulse) else $error("ack longer than one cycle");

   property p_no_irq_in_debug;
      @(posedge i_clk) disable iff (i_rst) (st_r.mode == ST_HALTED) |=> !o_irq_ack;
   endproperty
   a_no_irq_in_debug: assert property (p_no_irq_in_debug) else $error("irq taken in debug");

   property p_halt_beats_irq;
      @(posedge i_clk) disable iff (i_rst)
         (st_r.mode == ST_RUNNING) && i_debug_req |=> !o_irq_ack && o_halted && o_redir.kill;
   endproperty
   a_halt_beats_irq: assert property (p_halt_beats_irq) else $error("halt lost to irq");

   property p_ack_id_valid;
      @(posedge i_clk) disable iff (i_rst)
         o_irq_ack |-> IRQ_MASK[o_taken_interrupt_index] && st_r.mcause_irq &&
                       (st_r.mcause_code == o_taken_interrupt_index);
   endproperty
   a_ack_id_valid: assert property (p_ack_id_valid) else $error("bad taken index");

   property p_trigger_locked;
      @(posedge i_clk) disable iff (i_rst)
         (st_r.mode != ST_HALTED) && i_we && (i_addr == OFF_TDATA2) |=>
            (st_r.tdata2 == $past(st_r.tdata2));
   endproperty
   a_trigger_locked: assert property (p_trigger_locked) else $error("trigger written");

   property p_ecall_cause;
      @(posedge i_clk) disable iff (i_rst)
         (st_r.mode == ST_RUNNING) && i_insn.valid && (i_insn.insn == INSN_ECALL) &&
         !i_debug_req && !trig_hit && !irq_hit |=>
            o_redir.valid && (st_r.mcause_code == CAUSE_ECALL_M) && !st_r.mcause_irq;
   endproperty
   a_ecall_cause: assert property (p_ecall_cause) else $error("ecall not raised");

   property p_debug_return;
      @(posedge i_clk) disable iff (i_rst)
         (st_r.mode == ST_HALTED) && i_insn.valid && is_ebreak |=>
            o_redir.valid && (o_redir.pc == $past(i_halt_entry_address)) && o_halted;
   endproperty
   a_debug_return: assert property (p_debug_return) else $error("debug ebreak misrouted");

   // A halt request in normal mode parks the decode PC and the cause before jumping.
   property p_halt_entry;
      @(posedge i_clk) disable iff (i_rst)
         (st_r.mode == ST_RUNNING) && i_debug_req |=>
            (o_redir.pc == $past(i_halt_entry_address)) && (st_r.dpc == $past(i_insn.pc)) &&
            (st_r.dcause == DBG_CAUSE_HALTREQ);
   endproperty
   a_halt_entry: assert property (p_halt_entry) else $error("bad halt entry");

   // Debug CSR accesses are only legal while halted.
   property p_dbg_csr_locked;
      @(posedge i_clk) disable iff (i_rst)
         (st_r.mode != ST_HALTED) && (opc == OPC_SYSTEM) && (i_insn.insn[14:12] != 3'h0) &&
         (i_insn.insn[14:12] != 3'h4) && (csr_num >= CSR_DEBUG_LO) && (csr_num <= CSR_DEBUG_HI)
            |-> insn_illegal;
   endproperty
   a_dbg_csr_locked: assert property (p_dbg_csr_locked) else $error("debug csr open");

   // Without the fetch permit the status stays at reset-seen.
   property p_reset_wait;
      @(posedge i_clk) disable iff (i_rst)
         (st_r.mode == ST_HAVERESET) && !st_r.fe_s2 |=> o_havereset && !o_running && !o_halted;
   endproperty
   a_reset_wait: assert property (p_reset_wait) else $error("left reset early");

   // The handler address follows the table base and, when vectored, the taken index.
   property p_irq_target;
      @(posedge i_clk) disable iff (i_rst)
         o_irq_ack |-> o_redir.valid &&
            (o_redir.pc[31:MTVEC_BASE_LSB] == $past(st_r.mtvec_base)) &&
            (o_redir.pc[7:0] == ($past(st_r.mtvec_mode) ? {1'b0, o_taken_interrupt_index, 2'h0} :
                                 8'h00));
   endproperty
   a_irq_target: assert property (p_irq_target) else $error("bad handler address");
endmodule : tdc_trap_ctrl

// ---- tdc_far_side.sv ----
// Model of the interrupt sources and the debug module beside the trap controller.
`timescale 1ns/1ps
module tdc_far_side (
   input wire logic i_clk,
   input wire logic i_rst,
   input wire logic [31:0] i_raise,
   input wire logic i_halt,
   input wire logic i_irq_ack,
   input wire logic [4:0] i_index,
   input wire logic i_halted,
   output logic [31:0] o_irq = '0,
   output logic o_debug_req = 1'b0
);
   // A line stays up until the acknowledge names it, so a lost pulse shows as a repeat.
   // The halt request is a clocked level held until the core reports halted.
   always @(posedge i_clk) begin
      if (i_rst) begin
         o_irq <= '0;
         o_debug_req <= 1'b0;
      end else begin
         o_irq <= (o_irq | i_raise) & ~((i_irq_ack ? 32'h1 : 32'h0) << i_index);
         o_debug_req <= (o_debug_req | i_halt) & ~i_halted;
      end
   end
endmodule : tdc_far_side

// ---- testbench.sv ----
// Self-checking bench for the trap and debug-entry controller.
`timescale 1ns/1ps
module testbench;
   import tdc_pkg::*;
   typedef struct packed {logic irq; logic mode; logic [31:0] stim; logic [4:0] code;} tdc_row_t;
   localparam logic [31:0] NOP = 32'h0000_0013;
   localparam logic [31:0] PC = 32'h0000_0200;
   localparam logic [31:0] BASE = 32'h0000_1000;
   localparam logic [31:0] HALT = 32'h0000_0800;
   localparam logic [31:0] DEXC = 32'h0000_0900;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic fe = 1'b0;
   logic halt = 1'b0;
   logic [31:0] raise = '0;
   tdc_insn_t insn = '{1'b1, NOP, PC};
   logic [7:0] addr = '0;
   logic [31:0] wdata = '0;
   logic we = 1'b0;
   logic re = 1'b0;
   logic [31:0] irq;
   logic [31:0] rdata;
   logic [31:0] exp;
   logic dreq, ack, hrst, run, hlt;
   logic [4:0] idx;
   tdc_redir_t redir;
   int failures = 0;
   int tests_run = 0;
   tdc_row_t rows [10] = '{'{1'b1, 1'b0, 32'h8001_0888, 5'h1F}, '{1'b1, 1'b0, 32'h0, 5'h10},
      '{1'b1, 1'b1, 32'h0, 5'h0B}, '{1'b1, 1'b0, 32'h0, 5'h03}, '{1'b1, 1'b1, 32'h0, 5'h07},
      '{1'b0, 1'b0, INSN_ECALL, 5'h0B}, '{1'b0, 1'b0, 32'hFFFF_FFFF, 5'h02},
      '{1'b0, 1'b0, 32'h0000_0053, 5'h02}, '{1'b0, 1'b0, 32'h7B00_2073, 5'h02},
      '{1'b0, 1'b0, INSN_EBREAK, 5'h03}};

   // Free-running core clock at 25 MHz.
   always #20 clk = ~clk;

   tdc_far_side tdc_far_side_inst (.i_clk(clk), .i_rst(rst), .i_raise(raise), .i_halt(halt),
      .i_irq_ack(ack), .i_index(idx), .i_halted(hlt), .o_irq(irq), .o_debug_req(dreq));

   tdc_trap_ctrl tdc_trap_ctrl_inst (.i_clk(clk), .i_rst(rst), .i_irq(irq),
      .i_fetch_enable(fe), .i_debug_req(dreq), .i_halt_entry_address(HALT),
      .i_debug_exception_address(DEXC), .i_insn(insn), .i_addr(addr), .i_wdata(wdata),
      .i_we(we), .i_re(re), .o_rdata(rdata), .o_irq_ack(ack), .o_taken_interrupt_index(idx),
      .o_redir(redir), .o_havereset(hrst), .o_running(run), .o_halted(hlt));

   task automatic chk(input logic [31:0] got, input logic [31:0] want);
      tests_run++;
      if (got !== want) begin
         failures++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, want);
      end
   endtask : chk

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      addr <= a;
      wdata <= d;
      we <= 1'b1;
      @(posedge clk);
      we <= 1'b0;
      @(posedge clk);
   endtask : wr

   // Read data are looked at only in the cycle after the strobe.
   task automatic rd(input logic [7:0] a, input logic [31:0] want);
      addr <= a;
      re <= 1'b1;
      @(posedge clk);
      re <= 1'b0;
      #1;
      chk(rdata, want);
      @(posedge clk);
   endtask : rd

   // Offers one instruction for a single cycle and checks where fetch is sent.
   task automatic issue(input logic [31:0] ins, input logic [31:0] pc, input logic [31:0] want);
      insn <= '{1'b1, ins, pc};
      @(posedge clk);
      insn <= '{1'b1, NOP, PC};
      #1;
      chk(redir.valid, 1'b1);
      chk(redir.pc, want);
      @(posedge clk);
   endtask : issue

   // Waits a bounded time for the acknowledge, then checks that it lasted one cycle.
   task automatic wait_ack(input logic [4:0] id, input logic [31:0] pc);
      int n;
      #1;
      for (n = 0; n < 12 && ack !== 1'b1; n++) begin
         @(posedge clk);
         #1;
      end
      chk(ack, 1'b1);
      chk(idx, id);
      chk(redir.pc, pc);
      @(posedge clk);
      #1;
      chk(ack, 1'b0);
      @(posedge clk);
   endtask : wait_ack

   task automatic wait_st(input logic [1:0] want);
      int n;
      #1;
      for (n = 0; n < 12 && {hlt, run} !== want; n++) begin
         @(posedge clk);
         #1;
      end
      chk({hlt, run}, want);
   endtask : wait_st

   task automatic results();
      $display("tests_run=%0d failures=%0d", tests_run, failures);
      if (failures == 0 && tests_run > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask : results

   // Exactly one status line is up, and nothing is acknowledged while halted.
   always @(negedge clk) begin
      chk($countones({hrst, run, hlt}), 1);
      if (hlt === 1'b1) chk(ack, 1'b0);
   end

   // The whole sequence needs well under a thousand cycles.
   initial begin
      #(40 * 4000);
      failures++;
      results();
   end

   initial begin
      repeat (8) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      #1;
      chk(hrst, 1'b1);
      @(posedge clk);
      rd(OFF_MIE, 32'h0);
      rd(8'h3C, 32'h0);
      fe <= 1'b1;
      wait_st(2'b01);
      chk(hrst, 1'b0);
      @(posedge clk);
      $display("reset test done");
      foreach (rows[i]) begin
         wr(OFF_MTVEC, BASE | rows[i].mode);
         wr(OFF_MIE, 32'hFFFF_FFFF);
         exp = BASE + (rows[i].mode ? {rows[i].code, 2'b00} : 32'h0);
         // Lines go up before the global enable, since leftover lines are taken at once.
         raise <= rows[i].irq ? rows[i].stim : 32'h0;
         @(posedge clk);
         raise <= '0;
         wr(OFF_MSTATUS, rows[i].irq ? 32'h8 : 32'h0);
         if (rows[i].irq) begin
            wait_ack(rows[i].code, exp);
         end else issue(rows[i].stim, PC, BASE);
         rd(OFF_MCAUSE, {rows[i].irq, 26'h0, rows[i].code});
         rd(OFF_MEPC, PC);
         rd(OFF_MSTATUS, rows[i].irq ? 32'h80 : 32'h0);
         $display("row %0d done", i);
      end
      rd(OFF_MIE, 32'hFFFF_0888);
      // A halt request meets a pending interrupt in the same cycle.
      wr(OFF_MSTATUS, 32'h8);
      insn.valid <= 1'b0;
      raise <= 32'h8;
      @(posedge clk);
      raise <= '0;
      repeat (4) @(posedge clk);
      halt <= 1'b1;
      @(posedge clk);
      halt <= 1'b0;
      insn.valid <= 1'b1;
      wait_st(2'b10);
      chk(redir.pc, HALT);
      chk(redir.kill, 1'b1);
      @(posedge clk);
      rd(OFF_DPC, PC);
      rd(OFF_DCSR, 32'h0000_00C0);
      wr(OFF_DCSR, 32'h0000_8000);
      wr(OFF_TDATA2, 32'h0000_0300);
      wr(OFF_TDATA1, 32'h0000_0004);
      rd(OFF_TDATA1, 32'h2800_0004);
      issue(INSN_EBREAK, PC, HALT);
      issue(INSN_MRET, PC, DEXC);
      issue(32'hFFFF_FFFF, PC, DEXC);
      rd(OFF_MSTATUS, 32'h8);
      rd(OFF_MCAUSE, 32'h3);
      rd(OFF_DPC, PC);
      issue(INSN_DRET, PC, PC);
      wait_ack(5'h03, BASE);
      $display("debug entry test done");
      // Trigger writes outside Debug Mode are dropped; the trigger and ebreak still halt.
      wr(OFF_TDATA2, 32'h0);
      rd(OFF_TDATA2, 32'h0000_0300);
      issue(NOP, 32'h0000_0300, HALT);
      wait_st(2'b10);
      @(posedge clk);
      rd(OFF_DCSR, 32'h0000_8080);
      issue(INSN_DRET, PC, 32'h0000_0300);
      issue(INSN_EBREAK, PC, HALT);
      rd(OFF_DCSR, 32'h0000_8040);
      $display("trigger test done");
      // A second reset in mid-run clears the enables and waits for the permit again.
      rst <= 1'b1;
      repeat (2) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      #1;
      chk(hrst, 1'b1);
      @(posedge clk);
      rd(OFF_MIE, 32'h0);
      wait_st(2'b01);
      $display("second reset test done");
      results();
   end
endmodule : testbench
